//--- hw/sync_serial_transceiver.v
// Purpose: Three-wire synchronous serial transceiver with AHB-Lite registers
// Assumes: Single AHB-Lite slave, word transfers, one wait state per access
// Notes: Pins are split into in, out and active-low output enable
//
// Decided for this implementation: the AHB-Lite slave port.
`default_nettype none
`include "sio_defines.vh"

module sync_serial_transceiver (
    input wire core_clk,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire sck_pin_in,
    output reg sck_pin_out,
    output reg sck_pin_oe_b,
    input wire sdi_pin_in,
    output reg sdi_pin_out,
    output reg sdi_pin_oe_b,
    input wire sdo_pin_in,
    output reg sdo_pin_out,
    output reg sdo_pin_oe_b
);
    // Registers
    reg transceiver_enable_q;
    reg progress_q;
    reg [1:0] rate_select_q;
    reg auto_receive_start_q;
    reg clock_source_select_q;
    reg edge_select_q;
    reg duplex_select_q;
    reg [7:0] serial_clock_reload_q;
    reg [7:0] serial_data_buffer_q;
    reg [2:0] port_direction_reg_q;
    reg [2:0] port_data_q;
    reg transfer_done_flag_q;

    // Bus data phase
    reg pend_q;
    reg pend_write_q;
    reg [9:0] pend_idx_q;

    // Shift engine
    reg [2:0] bit_cnt_q;
    reg rx_bit_q;
    reg sck_q;
    reg sck_prev_q;

    wire [2:0] pin_sync;
    wire sck_s;
    wire sdi_s;
    wire div_tick;
    wire slave;
    wire act_edge;
    wire inact_edge;
    wire auto_go;
    wire run;
    wire last_bit;
    wire accept;
    wire wr_phase;
    wire [7:0] wbyte;
    wire [7:0] mode_rd;
    wire sel_mode;
    wire sel_reload;
    wire sel_buffer;
    wire sel_dir;
    wire sel_flag;
    wire sel_port;

    pin_synchronizer #(
        .W(3)
    ) u_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in({sdo_pin_in, sdi_pin_in, sck_pin_in}),
        .sync_out(pin_sync)
    );

    assign sck_s = pin_sync[0];
    assign sdi_s = pin_sync[1];

    assign slave = clock_source_select_q;

    // Divider only runs for an active master transfer; restart keeps
    // the first half period full length
    sio_rate_divider u_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(transceiver_enable_q & ~slave & progress_q),
        .rate_sel(rate_select_q),
        .reload(serial_clock_reload_q),
        .tick(div_tick)
    );

    // Active edge is the one that moves the clock to the edge_select level
    assign act_edge = slave ?
        ((sck_s != sck_prev_q) & (sck_s == edge_select_q)) :
        (div_tick & (sck_q != edge_select_q));
    assign inact_edge = slave ?
        ((sck_s != sck_prev_q) & (sck_s != edge_select_q)) :
        (div_tick & (sck_q == edge_select_q));

    // Slave may start on the peer's first clock edge when auto start is set
    assign auto_go = transceiver_enable_q & auto_receive_start_q & slave &
        ~progress_q & act_edge;
    assign run = transceiver_enable_q & (progress_q | auto_go);
    assign last_bit = run & inact_edge & (bit_cnt_q == `LAST_BIT);

    // Bus decode
    assign accept = hsel & hready & htrans[1] & hreadyout;
    assign wr_phase = pend_q & pend_write_q;
    assign wbyte = hwdata[7:0];
    assign sel_mode = (pend_idx_q == {2'b00, `SIO_MODE_IDX});
    assign sel_reload = (pend_idx_q == {2'b00, `SIO_RELOAD_IDX});
    assign sel_buffer = (pend_idx_q == {2'b00, `SIO_BUFFER_IDX});
    assign sel_dir = (pend_idx_q == {2'b00, `SIO_DIR_IDX});
    assign sel_flag = (pend_idx_q == {2'b00, `SIO_FLAG_IDX});
    assign sel_port = (pend_idx_q == {2'b00, `SIO_PORT_IDX});

    assign mode_rd = {transceiver_enable_q, progress_q, rate_select_q,
        auto_receive_start_q, clock_source_select_q, edge_select_q,
        duplex_select_q};

    // One wait state per access lets writes land before any read returns
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
            pend_write_q <= 1'b0;
            pend_idx_q <= 10'h000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            if (accept) begin
                pend_q <= 1'b1;
                pend_write_q <= hwrite;
                pend_idx_q <= haddr[11:2];
                hreadyout <= 1'b0;
            end else if (pend_q) begin
                pend_q <= 1'b0;
                hreadyout <= 1'b1;
                if (!pend_write_q) begin
                    if (sel_mode) begin
                        hrdata <= {24'h00_0000, mode_rd};
                    end else if (sel_buffer) begin
                        hrdata <= {24'h00_0000, serial_data_buffer_q};
                    end else if (sel_dir) begin
                        hrdata <= {29'h0000_0000, port_direction_reg_q};
                    end else if (sel_flag) begin
                        hrdata <= {31'h0000_0000, transfer_done_flag_q};
                    end else if (sel_port) begin
                        hrdata <= {29'h0000_0000, pin_sync};
                    end else begin
                        // Reload register is write-only and reads zero
                        hrdata <= 32'h0000_0000;
                    end
                end
            end
        end
    end

    // Mode, reload, direction and port data registers
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            transceiver_enable_q <= 1'b0;
            rate_select_q <= 2'h0;
            auto_receive_start_q <= 1'b0;
            clock_source_select_q <= 1'b0;
            edge_select_q <= 1'b0;
            duplex_select_q <= 1'b0;
            serial_clock_reload_q <= `SIO_RELOAD_RESET;
            port_direction_reg_q <= `SIO_DIR_RESET;
            port_data_q <= `SIO_PORT_RESET;
        end else if (wr_phase) begin
            if (sel_mode) begin
                transceiver_enable_q <= wbyte[`BIT_ENABLE];
                rate_select_q <= wbyte[`BIT_RATE_HI:`BIT_RATE_LO];
                auto_receive_start_q <= wbyte[`BIT_AUTO_RX];
                clock_source_select_q <= wbyte[`BIT_CLK_SRC];
                edge_select_q <= wbyte[`BIT_EDGE];
                duplex_select_q <= wbyte[`BIT_DUPLEX];
            end
            if (sel_reload) begin
                serial_clock_reload_q <= wbyte;
            end
            if (sel_dir) begin
                port_direction_reg_q <= wbyte[2:0];
            end
            if (sel_port) begin
                port_data_q <= wbyte[2:0];
            end
        end
    end

    // Progress bit: a start only counts if the block was already enabled,
    // so a combined enable-and-start write does not launch a transfer
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            progress_q <= 1'b0;
        end else if (wr_phase & sel_mode) begin
            progress_q <= wbyte[`BIT_PROGRESS] & transceiver_enable_q &
                wbyte[`BIT_ENABLE];
        end else if (last_bit | ~transceiver_enable_q) begin
            progress_q <= 1'b0;
        end else if (auto_go) begin
            progress_q <= 1'b1;
        end
    end

    // Done flag: hardware set wins over a software clear in the same cycle
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            transfer_done_flag_q <= 1'b0;
        end else if (last_bit) begin
            transfer_done_flag_q <= 1'b1;
        end else if (wr_phase & sel_flag) begin
            transfer_done_flag_q <= wbyte[`BIT_DONE_FLAG];
        end
    end

    // Shift buffer: sample on the active edge, shift on the inactive one
    // so the outgoing bit is stable around the peer's sampling edge
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_data_buffer_q <= `SIO_BUFFER_RESET;
            rx_bit_q <= 1'b0;
            bit_cnt_q <= 3'h0;
        end else begin
            if (!run) begin
                bit_cnt_q <= 3'h0;
            end
            if (wr_phase & sel_buffer) begin
                serial_data_buffer_q <= wbyte;
            end else if (run & inact_edge) begin
                serial_data_buffer_q <= {rx_bit_q,
                    serial_data_buffer_q[7:1]};
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (run & act_edge) begin
                rx_bit_q <= sdi_s;
            end
        end
    end

    // Master clock: one toggle per divider overflow, idle level between
    // bytes is the level opposite the active edge
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_q <= 1'b1;
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            if (slave | ~progress_q) begin
                sck_q <= ~edge_select_q;
            end else if (div_tick) begin
                sck_q <= ~sck_q;
            end
        end
    end

    // Pin muxing and direction override
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_pin_out <= 1'b0;
            sck_pin_oe_b <= 1'b1;
            sdi_pin_out <= 1'b0;
            sdi_pin_oe_b <= 1'b1;
            sdo_pin_out <= 1'b0;
            sdo_pin_oe_b <= 1'b1;
        end else if (transceiver_enable_q) begin
            sck_pin_out <= sck_q;
            sck_pin_oe_b <= slave;
            sdi_pin_out <= port_data_q[1];
            sdi_pin_oe_b <= ~port_direction_reg_q[1];
            sdo_pin_out <= serial_data_buffer_q[0];
            sdo_pin_oe_b <= ~duplex_select_q;
        end else begin
            sck_pin_out <= port_data_q[0];
            sck_pin_oe_b <= ~port_direction_reg_q[0];
            sdi_pin_out <= port_data_q[1];
            sdi_pin_oe_b <= ~port_direction_reg_q[1];
            sdo_pin_out <= port_data_q[2];
            sdo_pin_oe_b <= ~port_direction_reg_q[2];
        end
    end
endmodule

`default_nettype wire

//--- hw/sio_defines.vh
// Purpose: Shared constants for the synchronous serial transceiver
// Assumes: 32-bit AHB-Lite register access, one register per word
// Notes: Register indices times four give the byte address
//
// Operation
// - Enable bit 7 turns the clock and data-out port pins into serial pins; the data-in pin keeps port direction and data.
// - Progress bit 6 reads 1 during a transfer; writing 1 while already enabled starts one.
// - Rate field selects CPU clock, divided by 32, 16 or 8.
// - In external clock mode the rate field has no effect.
// - Bit 3 enables automatic start of reception.
// - Clock-source bit 2: 0 master drives clock, 1 slave takes clock.
// - Edge bit 1 picks falling (0) or rising (1) transfer edge.
// - Direction bit 0: 0 receive only, 1 full duplex.
// - While enabled, clock pin is input as slave and output as master.
// - While enabled, data out pin is output in duplex, input otherwise.
// - While disabled, pin directions follow the port direction register only.
// - One 8-bit buffer, reset zero, holds transmit then received byte.
// - Divider counter reloads from write-only reload register on overflow.
// - Master clock equals rate clock over twice (256 minus reload value).
// - Data shifts least significant bit first, full duplex.
// - A 3-bit counter ends the transfer after 8 bits, clearing progress.
// - A transfer ended by its eighth bit sets the done flag; one stopped by clearing enable or progress does not.
`ifndef SIO_DEFINES_VH
`define SIO_DEFINES_VH

`define SIO_MODE_IDX 8'hB4
`define SIO_RELOAD_IDX 8'hB5
`define SIO_BUFFER_IDX 8'hB6
`define SIO_DIR_IDX 8'hC5
`define SIO_FLAG_IDX 8'hC8
`define SIO_PORT_IDX 8'hD5

`define SIO_MODE_RESET 8'h00
`define SIO_RELOAD_RESET 8'h00
`define SIO_BUFFER_RESET 8'h00
`define SIO_DIR_RESET 3'h0
`define SIO_PORT_RESET 3'h0

`define BIT_ENABLE 7
`define BIT_PROGRESS 6
`define BIT_RATE_HI 5
`define BIT_RATE_LO 4
`define BIT_AUTO_RX 3
`define BIT_CLK_SRC 2
`define BIT_EDGE 1
`define BIT_DUPLEX 0
`define BIT_DONE_FLAG 0

`define RATE_DIV1 2'h0
`define RATE_DIV32 2'h1
`define RATE_DIV16 2'h2
`define RATE_DIV8 2'h3
`define PRE_LAST32 5'h1F
`define PRE_LAST16 4'hF
`define PRE_LAST8 3'h7
`define RELOAD_TOP 8'hFF
`define LAST_BIT 3'h7

`endif

//--- hw/pin_synchronizer.v
// Purpose: Two-flop synchronisers for pin inputs
// Assumes: Inputs are asynchronous to core_clk
// Notes: First stage feeds only the second stage
`default_nettype none

module pin_synchronizer #(
    parameter W = 3
) (
    input wire core_clk,
    input wire rst_b,
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate
endmodule

`default_nettype wire

//--- hw/sio_rate_divider.v
// Purpose: Prescaler plus auto-reload counter for the master clock
// Assumes: run drops between transfers so each byte starts from reload
// Notes: tick pulses once per (256 - reload) rate ticks
`default_nettype none
`include "sio_defines.vh"

module sio_rate_divider (
    input wire core_clk,
    input wire rst_b,
    input wire run,
    input wire [1:0] rate_sel,
    input wire [7:0] reload,
    output wire tick
);
    reg [4:0] pre_q;
    reg [7:0] cnt_q;
    reg rate_tick;

    always @* begin
        case (rate_sel)
            `RATE_DIV1: rate_tick = 1'b1;
            `RATE_DIV32: rate_tick = (pre_q == `PRE_LAST32);
            `RATE_DIV16: rate_tick = (pre_q[3:0] == `PRE_LAST16);
            `RATE_DIV8: rate_tick = (pre_q[2:0] == `PRE_LAST8);
            default: rate_tick = 1'b1;
        endcase
    end

    assign tick = run & rate_tick & (cnt_q == `RELOAD_TOP);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= 5'h00;
            cnt_q <= `SIO_RELOAD_RESET;
        end else if (!run) begin
            pre_q <= 5'h00;
            cnt_q <= reload;
        end else begin
            pre_q <= pre_q + 5'h01;
            if (rate_tick) begin
                if (cnt_q == `RELOAD_TOP) begin
                    cnt_q <= reload;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
endmodule

`default_nettype wire

//--- testbench/sync_serial_transceiver_checker.sv
// Purpose: Bus and pin assertions for the serial transceiver
// Assumes: Registers change at the end of the single wait state
// Notes: Mode, direction and port data are shadowed from bus writes
`default_nettype none
module sync_serial_transceiver_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sck_pin_out,
    input wire logic sck_pin_oe_b,
    input wire logic sdi_pin_oe_b,
    input wire logic sdo_pin_out,
    input wire logic sdo_pin_oe_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ph_q, wr_q, take, mw;
    logic [9:0] a_q;
    logic [7:0] mode_q;
    logic [2:0] dir_q, port_q;
    logic [4:0] tog_q;
    assign take = hsel && hready && htrans[1] && hreadyout;
    assign mw = ph_q && wr_q && a_q == 10'h0b4;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q <= 1'b0;
            mode_q <= 8'h00;
            dir_q <= 3'h0;
            port_q <= 3'h0;
            tog_q <= 5'h00;
        end else begin
            ph_q <= take;
            if (take) begin
                wr_q <= hwrite;
                a_q <= haddr[11:2];
            end
            if (mw) mode_q <= hwdata[7:0];
            if (ph_q && wr_q && a_q == 10'h0c5) dir_q <= hwdata[2:0];
            if (ph_q && wr_q && a_q == 10'h0d5) port_q <= hwdata[2:0];
            // Count driven clock edges only; the enabling step is not an edge
            if (mw) tog_q <= 5'h00;
            else if (!sck_pin_oe_b && !$past(sck_pin_oe_b) && sck_pin_out != $past(sck_pin_out))
                tog_q <= tog_q + 5'h01;
        end
    end
    sequence s_take;
        hsel && hready && htrans[1] && hreadyout;
    endsequence
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_wait_state: assert property (s_take |-> ##1 s_wait) else $error("wait state");
    chk_read_upper: assert property (s_take ##0 !hwrite |-> ##2 hrdata[31:8] == 24'h00_0000)
        else $error("read upper bits");
    chk_resp_okay: assert property (hresp == 1'b0) else $error("response");
    chk_clk_dir: assert property ($past(mode_q[7]) |-> sck_pin_oe_b == $past(mode_q[2]))
        else $error("clock pin direction");
    chk_out_dir: assert property ($past(mode_q[7]) |-> sdo_pin_oe_b == !$past(mode_q[0]))
        else $error("data out direction");
    chk_port_dir: assert property (!$past(mode_q[7]) |->
        {sdo_pin_oe_b, sdi_pin_oe_b, sck_pin_oe_b} == ~$past(dir_q)) else $error("port direction");
    chk_port_out: assert property (!$past(mode_q[7]) |->
        {sdo_pin_out, sck_pin_out} == {$past(port_q[2]), $past(port_q[0])}) else $error("port out");
    chk_clk_count: assert property (tog_q <= 5'd16) else $error("clock edges");
    chk_clk_idle: assert property (tog_q == 5'd16 |=> $stable(sck_pin_out))
        else $error("clock idle");
endmodule
`default_nettype wire

//--- testbench/serial_peer.sv
// Purpose: Serial peer on the far side of the three-wire link
// Assumes: Same edge convention as the device, least significant bit first
// Notes: Drives the clock only when asked, eight periods per byte
`default_nettype none
module serial_peer (
    input wire logic core_clk,
    input wire logic sck_w,
    input wire logic sdo_w,
    input wire logic edge_sel,
    input wire logic load,
    input wire logic go,
    input wire logic [7:0] tx,
    output logic sck_drv,
    output logic sdi_drv,
    output logic [7:0] sr,
    output int n_act
);
    timeunit 1ns;
    timeprecision 1ns;
    logic smp;
    initial begin
        sck_drv = 1'b0;
        sr = 8'h00;
    end
    assign sdi_drv = sr[0];
    // Idle level is set only once the device holds the new edge setting,
    // so the move to idle never looks like an active edge to an armed slave
    always @(posedge load) begin
        sr = tx;
        n_act = 0;
        repeat (4) @(posedge core_clk);
        sck_drv <= ~edge_sel;
    end
    always @(sck_w) begin
        if (!load && sck_w === edge_sel) begin
            smp = sdo_w;
            n_act++;
        end else if (!load) begin
            sr = {smp, sr[7:1]};
        end
    end
    // Eight cycles a half period leaves room for the pin synchronisers
    always @(posedge go) begin
        repeat (16) begin
            repeat (8) @(posedge core_clk);
            sck_drv <= ~sck_drv;
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_sync_serial_transceiver.sv
// Purpose: Self-checking bench for the serial transceiver
// Assumes: Register byte address is index times four
// Notes: Master half periods kept at eight cycles or more
`default_nettype none
module tb_sync_serial_transceiver;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] A_MODE = 32'h0000_02d0;
    localparam logic [31:0] A_RLD = 32'h0000_02d4;
    localparam logic [31:0] A_BUF = 32'h0000_02d8;
    localparam logic [31:0] A_DIR = 32'h0000_0314;
    localparam logic [31:0] A_FLAG = 32'h0000_0320;
    localparam logic [31:0] A_PORT = 32'h0000_0354;
    logic core_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hreadyout, hresp, sck_pin_out, sck_pin_oe_b, sdi_pin_out, sdi_pin_oe_b;
    logic sdo_pin_out, sdo_pin_oe_b, p_sck, p_sdi, sck_prev = 1'b0;
    logic p_load = 1'b0, p_go = 1'b0, p_edge = 1'b0;
    logic [7:0] p_tx = 8'h00, p_sr;
    int p_act, n_errors = 0, comparisons = 0, cyc = 0, last = 0, half = 0;
    wire logic sck_w = sck_pin_oe_b ? p_sck : sck_pin_out;
    wire logic sdi_w = sdi_pin_oe_b ? p_sdi : sdi_pin_out;
    wire logic sdo_w = sdo_pin_oe_b ? ~sdo_pin_out : sdo_pin_out;
    sync_serial_transceiver i_dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .sck_pin_in(sck_w), .sck_pin_out(sck_pin_out), .sck_pin_oe_b(sck_pin_oe_b),
        .sdi_pin_in(sdi_w), .sdi_pin_out(sdi_pin_out), .sdi_pin_oe_b(sdi_pin_oe_b),
        .sdo_pin_in(sdo_w), .sdo_pin_out(sdo_pin_out), .sdo_pin_oe_b(sdo_pin_oe_b));
    serial_peer i_peer (.core_clk(core_clk), .sck_w(sck_w), .sdo_w(sdo_w), .edge_sel(p_edge),
        .load(p_load), .go(p_go), .tx(p_tx), .sck_drv(p_sck), .sdi_drv(p_sdi), .sr(p_sr),
        .n_act(p_act));
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (sck_pin_out !== sck_prev) begin
            half = cyc - last;
            last = cyc;
        end
        sck_prev = sck_pin_out;
        if (cyc > 60000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
    function automatic int exp_half(input logic [1:0] r, input logic [7:0] rl);
        return (r == 2'b00 ? 1 : 256 >> (r + 2)) * (256 - rl);
    endfunction
    task automatic xfer(input logic src, auto, input logic [1:0] rate, input logic [7:0] rl,
        input logic eg, dup);
        logic [7:0] tx, px, m;
        tx = 8'($urandom);
        px = 8'($urandom);
        m = {1'b1, 1'b0, rate, auto, src, eg, dup};
        bus(1, A_BUF, {24'h00_0000, tx});
        bus(1, A_RLD, {24'h00_0000, rl});
        p_edge <= eg;
        p_tx <= px;
        p_load <= 1'b1;
        // Peer ignores the pin steps that the enabling write causes
        bus(1, A_MODE, {24'h00_0000, m});
        repeat (4) @(posedge core_clk);
        p_load <= 1'b0;
        if (!auto) bus(1, A_MODE, {24'h00_0000, m | 8'h40});
        p_go <= src;
        rd = 32'h0000_0000;
        while (rd[0] !== 1'b1) bus(0, A_FLAG, 32'h0000_0000);
        p_go <= 1'b0;
        bus(0, A_MODE, 32'h0000_0000);
        check("mode after", {24'h00_0000, m}, rd);
        bus(0, A_BUF, 32'h0000_0000);
        check("rx byte", {24'h00_0000, px}, rd);
        if (dup) check("peer byte", {24'h00_0000, tx}, {24'h00_0000, p_sr});
        check("edges", 32'd8, 32'(p_act));
        if (!src) check("half", 32'(exp_half(rate, rl)), 32'(half));
        bus(1, A_FLAG, 32'h0000_0000);
        bus(0, A_FLAG, 32'h0000_0000);
        check("flag clear", 32'h0000_0000, rd);
    endtask
    initial begin
        void'($urandom(32'hb6c30fdf));
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        bus(0, A_MODE, 32'h0000_0000);
        check("mode reset", 32'h0000_0000, rd);
        bus(0, A_BUF, 32'h0000_0000);
        check("buffer reset", 32'h0000_0000, rd);
        bus(1, A_RLD, 32'h0000_00a5);
        bus(0, A_RLD, 32'h0000_0000);
        check("reload read", 32'h0000_0000, rd);
        bus(0, 32'h0000_0100, 32'h0000_0000);
        check("unmapped", 32'h0000_0000, rd);
        bus(1, A_BUF, 32'hffff_ff5a);
        bus(0, A_BUF, 32'h0000_0000);
        check("buffer rw", 32'h0000_005a, rd);
        bus(1, A_MODE, 32'h0000_0040);
        bus(0, A_MODE, 32'h0000_0000);
        check("start while off", 32'h0000_0000, rd);
        bus(1, A_DIR, 32'h0000_0005);
        bus(1, A_PORT, 32'h0000_0007);
        repeat (4) @(posedge core_clk);
        bus(0, A_PORT, 32'h0000_0000);
        check("port pins", {29'h0, 1'b1, p_sdi, 1'b1}, rd);
        bus(1, A_DIR, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            xfer(0, 0, 2'(i), i % 4 == 0 ? 8'hf0 + 8'($urandom % 9) : 8'hff - 8'($urandom % 4),
                i[2], i[0] ^ i[2]);
        end
        for (int i = 0; i < 4; i++) begin
            xfer(1, i[1], 2'($urandom), 8'($urandom), i[0], ~i[0]);
        end
        results();
    end
endmodule
bind sync_serial_transceiver sync_serial_transceiver_checker i_chk (.core_clk(core_clk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sck_pin_out(sck_pin_out), .sck_pin_oe_b(sck_pin_oe_b), .sdi_pin_oe_b(sdi_pin_oe_b),
    .sdo_pin_out(sdo_pin_out), .sdo_pin_oe_b(sdo_pin_oe_b));
`default_nettype wire
